// File: hw/fbo_pkg.sv
// Summary of operation
// R1: Burst addresses follow length and order setting
// R2: Low program supply refuses writes, flags error
// R3: Write-protect low locks lockable blocks, flags error
// R4: Top boot: top two parameter, main blocks lockable
// R5: Bottom boot: low two parameter, main lockable
// R6: Unlocked blocks program and erase normally
// R7: Reset pin low disables device, locks all
// R8: Protection decided by reset, supply, write-protect
// R9: Chip enable low, reset high means active
// R10: Idle power save after read, data held
// R11: Chip enable high in read: standby, pins floating
// R12: Running operation finishes despite chip enable high
// R13: Command write needs chip and write enable low
// R14: Array changes only after two-write sequence
// R15: Latched command unaffected by supply, enable, engine
// R16: Read-array state after reset or supply rise
// R17: Host issues read-array after operation completes
// R18: Host ties flash reset to system reset; the host model drives it on its own and pulls it low alone at the end
// R19: Length codes: 001 four, 010 eight, 111 continuous
// R20: Order bit 0 interleaved, 1 linear
// R21: Parameter and status reads are single words
package fbo_pkg;

  // Bus word offsets
  localparam logic [7:0] REG_RCR    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Read configuration fields and reset value
  localparam int          RCR_MODE_BIT  = 15;
  localparam int          RCR_ORDER_BIT = 7;
  localparam int          RCR_LEN_LSB   = 0;
  localparam logic [15:0] RCR_RESET     = 16'h8001;

  // Burst length codes and order encoding
  localparam logic [2:0] LEN_4         = 3'h1;
  localparam logic [2:0] LEN_8         = 3'h2;
  localparam logic [2:0] LEN_CONT      = 3'h7;
  localparam logic       ORDER_LINEAR  = 1'h1;

  // Status bit positions
  localparam int SR_READY      = 7;
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_PROG_ERR   = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_LOCK_ERR   = 1;
  localparam int STAT_PWR_LSB  = 8;

  // Block geometry: main blocks are 32 Kword, parameter blocks 4 Kword
  localparam int MAIN_SHIFT  = 15;
  localparam int PARAM_SHIFT = 12;

  // Command codes on the low data byte
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR       = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;

  // Operation times and their cycle counts at the system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS  = 2000;
  localparam int ERASE_TIME_NS = 20000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Write engine states
  typedef enum logic [1:0] {WS_IDLE, WS_PROG_SETUP, WS_ERASE_SETUP, WS_BUSY} fbo_wsm_t;

  // Power states shown to software
  typedef enum logic [1:0] {PWR_RESET, PWR_ACTIVE, PWR_IDLE, PWR_STANDBY} fbo_pwr_t;

endpackage

// File: hw/fbo_burst_addr.sv
`timescale 1ns/10ps
module fbo_burst_addr #(
  parameter int AW = 20
) (
  // Burst start and progress
  input  wire logic [AW-1:0] start_i,
  input  wire logic [AW-1:0] beat_i,
  // Configuration
  input  wire logic [2:0]    len_i,
  input  wire logic          order_i,
  // Word address of this beat
  output logic [AW-1:0]      addr_o
);

  // R1: address ordering per beat
  always_comb begin
    // Continuous length and reserved codes count straight up
    addr_o = AW'(start_i + beat_i);
    if (len_i == fbo_pkg::LEN_4) begin
      // Wrap or interleave inside the aligned 4-word group
      if (order_i == fbo_pkg::ORDER_LINEAR) begin
        addr_o = {start_i[AW-1:2], 2'(start_i[1:0] + beat_i[1:0])};
      end else begin
        addr_o = {start_i[AW-1:2], start_i[1:0] ^ beat_i[1:0]};
      end
    end else if (len_i == fbo_pkg::LEN_8) begin
      // Same inside the aligned 8-word group
      if (order_i == fbo_pkg::ORDER_LINEAR) begin
        addr_o = {start_i[AW-1:3], 3'(start_i[2:0] + beat_i[2:0])};
      end else begin
        addr_o = {start_i[AW-1:3], start_i[2:0] ^ beat_i[2:0]};
      end
    end
  end

endmodule

// File: hw/fbo_lock_decode.sv
`timescale 1ns/10ps
module fbo_lock_decode #(
  parameter int AW       = 20,
  parameter bit TOP_BOOT = 1'b1
) (
  // Word address
  input  wire logic [AW-1:0] addr_i,
  // Block class
  output logic               lockable_o,
  output logic               param_o
);

  logic [2:0] param_idx;  // Parameter block index in its 32 Kword slot

  // Parameter slot is the highest main slot for top boot, the lowest for bottom
  always_comb begin
    param_idx = addr_i[fbo_pkg::MAIN_SHIFT-1:fbo_pkg::PARAM_SHIFT];
    if (TOP_BOOT) begin
      param_o = &addr_i[AW-1:fbo_pkg::MAIN_SHIFT];
      // R4: top two parameter blocks plus main blocks
      lockable_o = !param_o || (param_idx[2:1] == 2'h3);
    end else begin
      param_o = ~|addr_i[AW-1:fbo_pkg::MAIN_SHIFT];
      // R5: bottom two parameter blocks plus main blocks
      lockable_o = !param_o || (param_idx[2:1] == 2'h0);
    end
  end

endmodule

// File: hw/fbo_flash_ctrl.sv
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/10ps
module fbo_flash_ctrl #(
  parameter int AW       = 20,
  parameter int ARR_AW   = 8,
  parameter bit TOP_BOOT = 1'b1
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // Flash control pins
  input  wire logic          flash_ce_n_i,
  input  wire logic          flash_we_n_i,
  input  wire logic          flash_oe_n_i,
  input  wire logic          flash_adv_n_i,
  input  wire logic          flash_rst_n_i,
  input  wire logic          flash_wp_n_i,
  input  wire logic          burst_clk_i,
  // Supply monitors, high when at or above lockout level
  input  wire logic          vpp_ok_i,
  input  wire logic          vcc_ok_i,
  // Address and data pins
  input  wire logic [AW-1:0] flash_addr_i,
  input  wire logic [15:0]   data_pins_i,
  output logic [15:0]        data_pins_o,
  output logic               data_pins_oe_n_o,
  // Status
  output logic [1:0]         pwr_state_o,
  output logic               busy_o
);

  localparam int NPIN = 9 + AW + 16;
  // Enables and strobes reset to their inactive high level, so no false edge follows reset
  localparam logic [NPIN-1:0] PIN_IDLE = {4'hf, {(NPIN-4){1'b0}}};

  // Pin synchronisers; only the second stage is read
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;

  // Synchronised pins
  logic s_ce_n, s_we_n, s_oe_n, s_adv_n, s_rst_n, s_wp_n, s_bclk, s_vpp_ok, s_vcc_ok;
  logic [AW-1:0] s_addr;
  logic [15:0]   s_dq;

  // Edge history
  logic we_prev;
  logic ce_prev;
  logic bclk_prev;

  // Register file and engine state
  logic [15:0]       read_config_reg;         // read_config_reg
  logic [7:0]        sr;          // Sticky error bits
  fbo_pkg::fbo_wsm_t write_state_machine;         // write_state_machine
  logic [15:0]       op_cnt;      // Cycles left in operation
  logic              op_erase;    // Running operation is an erase
  logic [AW-1:0]     op_addr;     // Target word
  logic [15:0]       op_data;     // Program data
  logic              rd_status;   // command_interface reads status
  logic [AW-1:0]     burst_start; // Latched burst start
  logic [AW-1:0]     burst_beat;  // Beats since start
  logic [AW-1:0]     last_addr;   // Last location put on the pins
  logic [15:0]       mem [2**ARR_AW];

  // Derived terms
  logic          dev_rst, cmd_wr, second_wr, write_fail, good_second, op_done;
  logic          lockable, param_blk, start_lockable;
  logic [AW-1:0] burst_addr, cur_addr;
  logic          sync_mode, wb_req, wb_wr;
  logic [7:0]    sr_set, sr_clr, stat_byte;

  // Two-stage capture of every pin; buses settle long before they are used
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= {flash_ce_n_i, flash_we_n_i, flash_oe_n_i, flash_adv_n_i, flash_rst_n_i,
                   flash_wp_n_i, burst_clk_i, vpp_ok_i, vcc_ok_i, flash_addr_i, data_pins_i};
      pin_sync <= pin_meta;
    end
  end

  assign {s_ce_n, s_we_n, s_oe_n, s_adv_n, s_rst_n, s_wp_n, s_bclk, s_vpp_ok, s_vcc_ok,
          s_addr, s_dq} = pin_sync;

  // Edge history for write strobe, chip enable and burst clock
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      we_prev   <= 1'b1;
      ce_prev   <= 1'b1;
      bclk_prev <= 1'b0;
    end else begin
      we_prev   <= s_we_n;
      ce_prev   <= s_ce_n;
      bclk_prev <= s_bclk;
    end
  end

  // R7: reset pin low or core supply below lockout disables everything
  assign dev_rst = !s_rst_n || !s_vcc_ok;

  // R13: write taken on write-enable release with chip enable low
  assign cmd_wr = s_we_n && !we_prev && !ce_prev && !dev_rst;

  // Block class of the address on the pins
  fbo_lock_decode #(
    .AW       (AW),
    .TOP_BOOT (TOP_BOOT)
  ) u_lock (
    .addr_i     (s_addr),
    .lockable_o (lockable),
    .param_o    (param_blk)
  );

  // Burst start class decides whether bursting is allowed
  fbo_lock_decode #(
    .AW       (AW),
    .TOP_BOOT (TOP_BOOT)
  ) u_lock_start (
    .addr_i     (burst_start),
    .lockable_o (start_lockable),
    .param_o    (sync_mode)
  );

  // R8: supply low locks all, write-protect low locks the lockable set
  assign write_fail = !s_vpp_ok || (!s_wp_n && lockable);

  // R14: second write of a program, or a confirmed erase
  assign second_wr = cmd_wr && ((write_state_machine == fbo_pkg::WS_PROG_SETUP) ||
                                (write_state_machine == fbo_pkg::WS_ERASE_SETUP));
  assign good_second = second_wr && !write_fail &&
                       ((write_state_machine == fbo_pkg::WS_PROG_SETUP) || (s_dq[7:0] == fbo_pkg::CMD_CONFIRM));
  assign op_done = (write_state_machine == fbo_pkg::WS_BUSY) && (op_cnt == 16'h0001);

  // Sticky error causes; R2 and R3 set them on a refused second write
  always_comb begin
    sr_set = 8'h00;
    if (second_wr) begin
      if (!s_vpp_ok) begin
        sr_set[fbo_pkg::SR_SUPPLY_ERR] = 1'b1;
      end else if (!s_wp_n && lockable) begin
        sr_set[fbo_pkg::SR_LOCK_ERR] = 1'b1;
      end
      if (write_fail || (write_state_machine == fbo_pkg::WS_ERASE_SETUP && s_dq[7:0] != fbo_pkg::CMD_CONFIRM)) begin
        sr_set[fbo_pkg::SR_ERASE_ERR] = (write_state_machine == fbo_pkg::WS_ERASE_SETUP);
        sr_set[fbo_pkg::SR_PROG_ERR]  = (write_state_machine == fbo_pkg::WS_PROG_SETUP);
      end
    end
    sr_clr = 8'h00;
    if (cmd_wr && (write_state_machine == fbo_pkg::WS_IDLE) && s_dq[7:0] == fbo_pkg::CMD_CLEAR) begin
      sr_clr = 8'hff;
    end
    if (wb_wr && wb_adr_i == fbo_pkg::REG_STATUS && wb_sel_i[0]) begin
      sr_clr = sr_clr | wb_dat_i[7:0];
    end
  end

  // Error bits: a new error wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sr <= 8'h00;
    end else begin
      sr <= (sr & ~sr_clr) | sr_set;
    end
  end

  // Status byte with ready; the cast comes before the shift so bit 7 survives
  assign stat_byte = sr | (8'(write_state_machine != fbo_pkg::WS_BUSY) << fbo_pkg::SR_READY);

  // Write engine; refused or broken sequences fall back to idle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_state_machine      <= fbo_pkg::WS_IDLE;
      op_cnt   <= 16'h0000;
      op_erase <= 1'b0;
      op_addr  <= '0;
      op_data  <= 16'h0000;
    end else if (dev_rst) begin
      // R7: disabled device aborts and accepts nothing
      write_state_machine    <= fbo_pkg::WS_IDLE;
      op_cnt <= 16'h0000;
    end else begin
      unique case (write_state_machine)
        fbo_pkg::WS_IDLE: begin
          if (cmd_wr && s_dq[7:0] == fbo_pkg::CMD_PROGRAM) begin
            write_state_machine <= fbo_pkg::WS_PROG_SETUP;
          end else if (cmd_wr && s_dq[7:0] == fbo_pkg::CMD_ERASE) begin
            write_state_machine <= fbo_pkg::WS_ERASE_SETUP;
          end
        end
        fbo_pkg::WS_PROG_SETUP, fbo_pkg::WS_ERASE_SETUP: begin
          // R6: unlocked block with good supply starts the operation
          if (good_second) begin
            write_state_machine      <= fbo_pkg::WS_BUSY;
            op_erase <= (write_state_machine == fbo_pkg::WS_ERASE_SETUP);
            op_addr  <= s_addr;
            op_data  <= s_dq;
            op_cnt   <= (write_state_machine == fbo_pkg::WS_ERASE_SETUP) ? 16'(fbo_pkg::ERASE_CYCLES)
                                                         : 16'(fbo_pkg::PROG_CYCLES);
          end else if (second_wr) begin
            write_state_machine <= fbo_pkg::WS_IDLE;
          end
        end
        fbo_pkg::WS_BUSY: begin
          // R12: chip enable plays no part while running
          op_cnt <= op_cnt - 16'h0001;
          if (op_done) begin
            write_state_machine <= fbo_pkg::WS_IDLE;
          end
        end
      endcase
    end
  end

  // Array model; program only clears bits, erase sets the whole model to ones
  always_ff @(posedge sys_clk_i) begin
    if (op_done && op_erase) begin
      for (int i = 0; i < 2**ARR_AW; i++) begin
        mem[i] <= 16'hffff;
      end
    end else if (op_done) begin
      mem[op_addr[ARR_AW-1:0]] <= mem[op_addr[ARR_AW-1:0]] & op_data;
    end
  end

  // R16: read-array after reset and after core supply returns
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_status <= 1'b0;
    end else if (dev_rst) begin
      rd_status <= 1'b0;
    end else if (second_wr) begin
      // R17: status stays on the pins until read-array arrives
      rd_status <= 1'b1;
    end else if (cmd_wr && write_state_machine != fbo_pkg::WS_PROG_SETUP && write_state_machine != fbo_pkg::WS_ERASE_SETUP) begin
      // R15: only commands and device reset move the read state
      if (s_dq[7:0] == fbo_pkg::CMD_READ_ARRAY && write_state_machine == fbo_pkg::WS_IDLE) begin
        rd_status <= 1'b0;
      end else if (s_dq[7:0] == fbo_pkg::CMD_READ_STATUS || s_dq[7:0] == fbo_pkg::CMD_PROGRAM ||
                   s_dq[7:0] == fbo_pkg::CMD_ERASE) begin
        rd_status <= 1'b1;
      end
    end
  end

  // Burst progress: address-valid latches the start, each burst-clock rise steps
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_start <= '0;
      burst_beat  <= '0;
    end else if (!s_adv_n) begin
      burst_start <= s_addr;
      burst_beat  <= '0;
    end else if (s_bclk && !bclk_prev && !s_ce_n && !read_config_reg[fbo_pkg::RCR_MODE_BIT] &&
                 !sync_mode && !rd_status) begin
      // R21: parameter and status reads never advance
      burst_beat <= AW'(burst_beat + 1'b1);
    end
  end

  // R20: continuous length is forced to linear order
  fbo_burst_addr #(
    .AW (AW)
  ) u_burst (
    .start_i (burst_start),
    .beat_i  (burst_beat),
    .len_i   (read_config_reg[fbo_pkg::RCR_LEN_LSB +: 3]),
    .order_i (read_config_reg[fbo_pkg::RCR_ORDER_BIT] || read_config_reg[fbo_pkg::RCR_LEN_LSB +: 3] == fbo_pkg::LEN_CONT),
    .addr_o  (burst_addr)
  );

  // R1: burst mode reads the ordered address, page mode the pins
  assign cur_addr = read_config_reg[fbo_pkg::RCR_MODE_BIT] ? s_addr : burst_addr;

  // Output pins; data is refreshed each cycle so it stays valid while idle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_pins_o      <= 16'h0000;
      data_pins_oe_n_o <= 1'b1;
      last_addr        <= '0;
    end else begin
      // R11: standby or disabled floats the pins regardless of output enable
      data_pins_oe_n_o <= dev_rst || s_ce_n || s_oe_n;
      if (!dev_rst && !s_ce_n) begin
        // R10: last data stays until another location is read
        data_pins_o <= rd_status ? {8'h00, stat_byte} : mem[cur_addr[ARR_AW-1:0]];
        last_addr   <= cur_addr;
      end
    end
  end

  // Power state and busy flag
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_state_o <= fbo_pkg::PWR_RESET;
      busy_o      <= 1'b0;
    end else begin
      busy_o <= (write_state_machine == fbo_pkg::WS_BUSY) && !dev_rst;
      if (dev_rst) begin
        pwr_state_o <= fbo_pkg::PWR_RESET;
      end else if (write_state_machine == fbo_pkg::WS_BUSY) begin
        // R12: running operation keeps active power
        pwr_state_o <= fbo_pkg::PWR_ACTIVE;
      end else if (s_ce_n) begin
        pwr_state_o <= fbo_pkg::PWR_STANDBY;
      end else if (cur_addr == last_addr && !rd_status) begin
        // R10: idle_power_save once the read location is settled
        pwr_state_o <= fbo_pkg::PWR_IDLE;
      end else begin
        // R9: chip enable low with reset high is active
        pwr_state_o <= fbo_pkg::PWR_ACTIVE;
      end
    end
  end

  // Wishbone: one wait state, ack for one cycle, unmapped reads give zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge at which the master sees ack
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      read_config_reg      <= fbo_pkg::RCR_RESET;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr && wb_adr_i == fbo_pkg::REG_RCR) begin
        // R19: burst length code written here
        if (wb_sel_i[0]) read_config_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) read_config_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          fbo_pkg::REG_RCR:    wb_dat_o <= {16'h0000, read_config_reg};
          fbo_pkg::REG_STATUS: wb_dat_o <= {22'h000000, pwr_state_o, stat_byte};
          default:             wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence seq_setup_write;
    (write_state_machine == fbo_pkg::WS_PROG_SETUP || write_state_machine == fbo_pkg::WS_ERASE_SETUP) && cmd_wr;
  endsequence

  a_ce_high_write: assert property ( // R13
    (write_state_machine == fbo_pkg::WS_IDLE && ce_prev) |=> write_state_machine == fbo_pkg::WS_IDLE)
    else $error("write taken with chip enable high");
  a_supply_refuse: assert property ( // R2
    (seq_setup_write and !s_vpp_ok) |=> sr[fbo_pkg::SR_SUPPLY_ERR] && write_state_machine == fbo_pkg::WS_IDLE)
    else $error("low supply write not refused");
  a_locked_refuse: assert property ( // R3
    (seq_setup_write and (s_vpp_ok && !s_wp_n && lockable))
      |=> sr[fbo_pkg::SR_LOCK_ERR] && write_state_machine == fbo_pkg::WS_IDLE)
    else $error("locked block write not refused");
  a_unlocked_runs: assert property ( // R6
    good_second |=> write_state_machine == fbo_pkg::WS_BUSY ##1 busy_o)
    else $error("unlocked write did not start");
  a_reset_disables: assert property ( // R7
    dev_rst |=> write_state_machine == fbo_pkg::WS_IDLE && pwr_state_o == fbo_pkg::PWR_RESET && data_pins_oe_n_o)
    else $error("reset did not disable device");
  a_standby_float: assert property ( // R11
    (s_ce_n && write_state_machine != fbo_pkg::WS_BUSY && !dev_rst)
      |=> data_pins_oe_n_o && pwr_state_o == fbo_pkg::PWR_STANDBY)
    else $error("standby pins not floating");
  a_busy_active: assert property ( // R12
    (write_state_machine == fbo_pkg::WS_BUSY && !dev_rst) |=> pwr_state_o == fbo_pkg::PWR_ACTIVE)
    else $error("operation left active power");
  a_two_write: assert property ( // R14
    $rose(write_state_machine == fbo_pkg::WS_BUSY) |-> $past(second_wr))
    else $error("operation began without two writes");
  a_status_holds: assert property ( // R15
    (rd_status && !cmd_wr && !dev_rst) |=> rd_status)
    else $error("read state changed without command");
  a_array_default: assert property ( // R16
    dev_rst |=> !rd_status)
    else $error("read array not restored");

endmodule

// File: sim/fbo_host_model.sv
`timescale 1ns/10ps
module fbo_host_model (
  // System clock
  input  wire logic   clk_i,
  // Flash control pins
  output logic        ce_n_o,
  output logic        we_n_o,
  output logic        oe_n_o,
  output logic        adv_n_o,
  output logic        rst_n_o,
  output logic        bclk_o,
  // Address and data bus
  output logic [19:0] addr_o,
  output logic [15:0] data_o
);
  // Deselected, flash held in reset until the system leaves it
  initial begin
    {ce_n_o, we_n_o, oe_n_o, adv_n_o, rst_n_o, bclk_o} = 6'h3c;
    addr_o = 20'h00000;
    data_o = 16'h0000;
  end
  task automatic set_rst(input logic v);
    @(posedge clk_i);
    rst_n_o <= v;
  endtask
  // both enables low, held around the we_n rise
  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {ce_n_o, we_n_o} <= 2'b00;
    addr_o <= a;
    data_o <= d;
    repeat (4) @(posedge clk_i);
    we_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ce_n_o <= 1'b1;
    // Released bus shows no stale value
    data_o <= ~d;
    repeat (3) @(posedge clk_i);
  endtask
  // Selected read; burst clock runs only inside the burst
  task automatic rd(input logic [19:0] a, input int beats);
    @(posedge clk_i);
    {ce_n_o, oe_n_o, adv_n_o} <= 3'b000;
    addr_o <= a;
    repeat (3) @(posedge clk_i);
    adv_n_o <= 1'b1;
    #37;
    repeat (beats) begin
      bclk_o = 1'b1;
      #80 bclk_o = 1'b0;
      #80;
    end
    repeat (4) @(posedge clk_i);
  endtask
  // Deselect
  task automatic desel;
    @(posedge clk_i);
    {ce_n_o, oe_n_o} <= 2'b11;
  endtask
endmodule

// File: sim/fbo_flash_ctrl_tb.sv
`timescale 1ns/10ps
module fbo_flash_ctrl_tb;
  // Clock, reset, bus and pins
  logic        sys_clk_i, resetn_i, wb_cyc, wb_stb, wb_we, wb_ack, wp_n, vpp_ok, vcc_ok;
  logic        ce_n, we_n, oe_n, adv_n, rst_n, bclk, oe_n_o, busy;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_q, q;
  logic [19:0] addr, a;
  logic [15:0] din, dout;
  logic [1:0]  pwr, e;
  int          failures, checked, seed;
  // Protection cases: supply, write protect, region base and span
  logic [4:0]  vpp_t = 5'b11110;
  logic [4:0]  wp_t  = 5'b10001;
  logic [19:0] base_t [5] = '{20'hf8000, 20'h00000, 20'hfe000, 20'hf8000, 20'h00000};
  logic [19:0] span_t [5] = '{20'h06000, 20'hf8000, 20'h02000, 20'h06000, 20'hf8000};

  fbo_flash_ctrl fbo_flash_ctrl_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .flash_ce_n_i(ce_n), .flash_we_n_i(we_n), .flash_oe_n_i(oe_n), .flash_adv_n_i(adv_n),
    .flash_rst_n_i(rst_n), .flash_wp_n_i(wp_n), .burst_clk_i(bclk), .vpp_ok_i(vpp_ok),
    .vcc_ok_i(vcc_ok), .flash_addr_i(addr), .data_pins_i(din), .data_pins_o(dout),
    .data_pins_oe_n_o(oe_n_o), .pwr_state_o(pwr), .busy_o(busy));
  fbo_host_model fbo_host_model_i (.clk_i(sys_clk_i), .ce_n_o(ce_n), .we_n_o(we_n),
    .oe_n_o(oe_n), .adv_n_o(adv_n), .rst_n_o(rst_n), .bclk_o(bclk), .addr_o(addr),
    .data_o(din));

  // Free-running system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, we, ad, d, 4'hf};
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_q;
    {wb_cyc, wb_stb} <= 2'b00;
    if (n >= 50) begin
      failures++;
      final_report();
    end
  endtask
  // Expected {supply error, lock error} from the protection table
  function automatic logic [1:0] exp_err(input logic v, input logic w, input logic [19:0] ad);
    if (!v) return 2'b10;
    return {1'b0, !w && (ad < 20'hf8000 || ad >= 20'hfe000)};
  endfunction
  // Expected word address after b beats: 0 interleaved four, 1 linear eight, 2 continuous
  function automatic logic [19:0] exp_burst(input logic [19:0] s, input int b, input int k);
    if (k == 0) return {s[19:2], s[1:0] ^ 2'(b)};
    if (k == 1) return {s[19:3], 3'(s[2:0] + 3'(b))};
    return s + 20'(b);
  endfunction

  initial begin
    {resetn_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {wp_n, vpp_ok, vcc_ok} = 3'b111;
    failures = 0;
    checked = 0;
    seed = $urandom(66);
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    fbo_host_model_i.set_rst(1'b1);
    wb(1'b0, 8'h00, 32'h0);
    check("rcr reset", 32'h8001, q);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped read", 32'h0, q);
    check("standby pwr", 32'd3, {30'd0, pwr});
    check("standby float", 32'd1, {31'd0, oe_n_o});
    fbo_host_model_i.rd(20'h00010, 0);
    check("active pwr", 32'd1, {31'd0, ^pwr});
    check("read drives", 32'd0, {31'd0, oe_n_o});
    fbo_host_model_i.desel();
    for (int i = 0; i < 5; i++) begin
      {vpp_ok, wp_n} <= {vpp_t[i], wp_t[i]};
      a = base_t[i] + 20'($urandom % span_t[i]);
      wb(1'b1, 8'h04, 32'hff);
      // Last case erases an unlocked main block, the others program
      fbo_host_model_i.cmd(a, i == 4 ? 16'h0020 : 16'h0040);
      fbo_host_model_i.cmd(a, i == 4 ? 16'h00d0 : 16'($urandom));
      if (busy === 1'b1) check("busy not standby", 32'd1, {31'd0, pwr !== 2'd3});
      for (int n = 0; busy !== 1'b0; n++) begin
        @(posedge sys_clk_i);
        if (n > 3000) begin
          failures++;
          final_report();
        end
      end
      e = exp_err(vpp_t[i], wp_t[i], a);
      // Status stays on the pins until read-array is written
      fbo_host_model_i.rd(a, 0);
      check("pin status", {30'd0, e}, {30'd0, dout[3], dout[1]});
      check("pin ready", 32'd1, {31'd0, dout[7]});
      wb(1'b0, 8'h04, 32'h0);
      check("error bits", {30'd0, e}, {30'd0, q[3], q[1]});
      check("ready", 32'd1, {31'd0, q[7]});
      fbo_host_model_i.cmd(a, 16'h00ff);
      if (i == 4) begin
        fbo_host_model_i.rd(a, 0);
        check("erased word", 32'hffff, {16'd0, dout});
        fbo_host_model_i.desel();
      end
    end
    // Burst modes: interleaved four, linear eight, continuous
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h00, i == 0 ? 32'h0001 : i == 1 ? 32'h0082 : 32'h0087);
      a = 20'($urandom % 20'hf8000);
      fbo_host_model_i.rd(a, 9);
      check("burst drives", 32'd0, {31'd0, oe_n_o});
      check("burst addr", {12'd0, exp_burst(a, 9, i)}, {12'd0, fbo_flash_ctrl_i.burst_addr});
      fbo_host_model_i.desel();
    end
    fbo_host_model_i.set_rst(1'b0);
    repeat (5) @(posedge sys_clk_i);
    check("reset pwr", 32'd0, {30'd0, pwr});
    check("reset float", 32'd1, {31'd0, oe_n_o});
    final_report();
  end
endmodule
